// [dsc_cfg.svh]
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define DSC_CNT_W      16
`define DSC_CNT_ZERO   16'h0000
`define DSC_CNT_ONE    16'h0001
`define DSC_CH_W       3
`define DSC_DATA_W     16
`define DSC_MODE_W     2
`define DSC_MODE_SINGLE 2'h0
`define DSC_MODE_BLOCK  2'h1
`define DSC_MODE_REP_SINGLE 2'h2
`define DSC_MODE_REP_BLOCK  2'h3
`define DSC_OWN_CH     3'h0
`endif

// [dsc_pkg.sv]
`include "dsc_cfg.svh"
package dsc_pkg;
	typedef logic [`DSC_CNT_W-1:0] dsc_cnt_t;
	typedef enum logic [1:0] {
		DSC_IDLE = 2'h0,
		DSC_WAIT = 2'h1,
		DSC_XFER = 2'h3
	} dsc_state_t;
	typedef struct packed {
		logic                   wr;
		logic                   from_dma;
		logic [`DSC_CH_W-1:0]   ch;
		dsc_cnt_t               data;
	} dsc_wr_t;
	typedef struct packed {
		logic [`DSC_DATA_W-1:0] data;
	} dsc_word_t;
	typedef struct packed {
		logic rmw_active;
		logic dma_cycle;
		logic new_irq;
	} dsc_flag_t;
endpackage

// [dsc_buf.sv]
`timescale 1ns/100ps
`default_nettype none
module dsc_buf
	import dsc_pkg::*;
(
	// clock, reset
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	// fill side
	input  wire logic       in_valid_in,
	input  wire dsc_word_t  in_word_in,
	output var  logic       in_ready_out,
	// drain side
	output var  logic       out_valid_out,
	output var  dsc_word_t  out_word_out,
	input  wire logic       out_ready_in
);
	dsc_word_t  mem [2];
	logic       rd_ptr;
	logic       wr_ptr;
	logic [1:0] used;
	logic       next_rd_ptr;
	logic       next_wr_ptr;
	logic [1:0] next_used;
	logic       push;
	logic       pop;
	logic       has_word;
	logic       next_has_word;
	dsc_word_t  head;
	dsc_word_t  next_head;

	always_comb begin
		push        = in_valid_in && (used != 2'h2);
		pop         = (used != 2'h0) && out_ready_in;
		next_wr_ptr = wr_ptr ^ push;
		next_rd_ptr = rd_ptr ^ pop;
		next_used   = used + {1'b0, push} - {1'b0, pop};
		next_has_word = (next_used != 2'h0);
		next_head     = head;
		// head word kept in a register so the drain side sees a flop
		if (pop && (used == 2'h2)) begin
			next_head = mem[next_rd_ptr];
		end else if (push && ((used == 2'h0) || pop)) begin
			next_head = in_word_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			used   <= 2'h0;
			has_word <= 1'b0;
			head     <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			used   <= next_used;
			has_word <= next_has_word;
			head     <= next_head;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_word_in;
		end
	end

	assign in_ready_out  = (used != 2'h2);
	assign out_valid_out = has_word;
	assign out_word_out  = head;
endmodule
`default_nettype wire

// [dsc_chan.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dsc_cfg.svh"
module dsc_chan
	import dsc_pkg::*;
(
	// clock, reset
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	// register writes
	input  wire dsc_wr_t    size_wr_in,
	input  wire logic       enable_wr_in,
	input  wire logic       enable_val_in,
	input  wire logic       enable_from_dma_in,
	input  wire logic [1:0] mode_in,
	// triggers and data
	input  wire logic       trig_in,
	input  wire dsc_word_t  src_word_in,
	// peripheral flag model
	input  wire dsc_flag_t  flag_in,
	input  wire logic       flag_clear_in,
	// outputs, drain ready input
	output logic            channel_enable_bit_out,
	output dsc_cnt_t        transfer_count_register_out,
	output logic            busy_out,
	output logic            done_out,
	output logic            irq_flag_out,
	output logic            out_valid_out,
	output dsc_word_t       out_word_out,
	input  wire logic       out_ready_in
);
	dsc_state_t state;
	dsc_state_t next_state;
	dsc_cnt_t   count;
	dsc_cnt_t   next_count;
	dsc_cnt_t   shadow;
	dsc_cnt_t   next_shadow;
	logic       en;
	logic       next_en;
	logic       done;
	logic       next_done;
	logic       irq;
	logic       next_irq;
	logic       busy;
	logic       buf_ready;
	logic       buf_valid;
	dsc_word_t  buf_word;
	logic       xfer_ok;
	logic       size_ok;
	logic       en_ok;

	function automatic logic cpu_write(input logic wr, input logic from_dma);
		return wr && !from_dma;
	endfunction

	dsc_buf u_buf (
		.clk_in        (clk_in),
		.arst_n_in     (arst_n_in),
		.in_valid_in   (state == DSC_XFER),
		.in_word_in    (src_word_in),
		.in_ready_out  (buf_ready),
		.out_valid_out (buf_valid),
		.out_word_out  (buf_word),
		.out_ready_in  (out_ready_in)
	);

	always_comb begin
		size_ok     = cpu_write(size_wr_in.wr, size_wr_in.from_dma);
		en_ok       = cpu_write(enable_wr_in, enable_from_dma_in);
		xfer_ok     = (state == DSC_XFER) && buf_ready;
		next_state  = state;
		next_count  = count;
		next_shadow = shadow;
		next_en     = en;
		next_done   = 1'b0;
		if (en_ok) begin
			next_en = enable_val_in;
		end
		// falling enable: no reload on silicon
		case (state)
			DSC_IDLE: begin
				if (en_ok && enable_val_in) begin
					next_state = DSC_WAIT;
				end
			end
			DSC_WAIT: begin
				if (trig_in) begin
					next_state = DSC_XFER;
				end
			end
			DSC_XFER: begin
				if (xfer_ok) begin
					if (count <= `DSC_CNT_ONE) begin
						next_count = shadow;
						next_done  = 1'b1;
						if (mode_in == `DSC_MODE_REP_SINGLE || mode_in == `DSC_MODE_REP_BLOCK) begin
							next_state = DSC_WAIT;
						end else begin
							next_state = DSC_IDLE;
							next_en    = 1'b0;
						end
					end else begin
						next_count = count - `DSC_CNT_ONE;
						next_state = DSC_WAIT;
					end
				end
			end
			default: next_state = DSC_IDLE;
		endcase
		if (state != DSC_IDLE && en_ok && !enable_val_in && count != `DSC_CNT_ZERO) begin
			next_state = DSC_WAIT;
		end
		if (size_ok) begin
			next_count = size_wr_in.data;
			if (state == DSC_IDLE && !en) begin
				next_shadow = size_wr_in.data;
			end
		end
		// RMW interleaved with dma cycle drops new flag; old stays
		next_irq = irq;
		if (flag_in.new_irq && !(flag_in.rmw_active && flag_in.dma_cycle)) begin
			next_irq = 1'b1;
		end else if (flag_clear_in) begin
			next_irq = 1'b0;
		end
		if (flag_in.rmw_active && flag_in.dma_cycle && !flag_clear_in && irq) begin
			next_irq = 1'b1;
		end
		busy = (next_state != DSC_IDLE);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state  <= DSC_IDLE;
			count  <= `DSC_CNT_ZERO;
			shadow <= `DSC_CNT_ZERO;
			en     <= 1'b0;
			done   <= 1'b0;
			irq    <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			state  <= next_state;
			count  <= next_count;
			shadow <= next_shadow;
			en     <= next_en;
			done   <= next_done;
			irq    <= next_irq;
			busy_out <= busy;
		end
	end

	assign channel_enable_bit_out      = en;
	assign transfer_count_register_out = count;
	assign done_out                    = done;
	assign irq_flag_out                = irq;
	assign out_valid_out               = buf_valid;
	assign out_word_out                = buf_word;

	a_reload_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(xfer_ok && count <= `DSC_CNT_ONE && !size_ok) |=> (count == $past(shadow)))
		else $error("count not reloaded at zero");
	a_no_fall_reload: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(en_ok && !enable_val_in && !xfer_ok && !size_ok) |=> $stable(count))
		else $error("enable fall changed count");
	a_idle_load: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(size_ok && state == DSC_IDLE && !en) |=> (count == $past(size_wr_in.data)) && (shadow == count))
		else $error("idle size write not loaded");
	a_active_load: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(size_ok && state != DSC_IDLE) |=> (count == $past(size_wr_in.data)))
		else $error("active size write not applied");
	a_dma_blocked: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(size_wr_in.wr && size_wr_in.from_dma && state == DSC_IDLE) |=> $stable(count) && $stable(shadow))
		else $error("dma write changed channel");
	sequence s_last_single;
		xfer_ok && (count <= `DSC_CNT_ONE) && !size_ok && !en_ok && (mode_in == `DSC_MODE_SINGLE || mode_in == `DSC_MODE_BLOCK);
	endsequence
	sequence s_last_repeat;
		xfer_ok && (count <= `DSC_CNT_ONE) && !size_ok && !en_ok && en && (mode_in == `DSC_MODE_REP_SINGLE || mode_in == `DSC_MODE_REP_BLOCK);
	endsequence
	sequence s_idle_off;
		(state == DSC_IDLE) && !en && done && (count == $past(shadow));
	endsequence
	sequence s_rearmed;
		(state == DSC_WAIT) && en && done && (count == $past(shadow));
	endsequence
	a_single_end: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		s_last_single |=> s_idle_off)
		else $error("single transfer did not stop");
	a_repeat_rearm: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		s_last_repeat |=> s_rearmed)
		else $error("repeat transfer did not rearm");
	a_irq_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(flag_in.new_irq && !(flag_in.rmw_active && flag_in.dma_cycle)) |=> irq)
		else $error("new flag not set");
	a_irq_drop: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(!irq && flag_in.new_irq && flag_in.rmw_active && flag_in.dma_cycle) |=> !irq)
		else $error("dropped flag appeared");
	a_irq_keep: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(irq && flag_in.rmw_active && flag_in.dma_cycle && !flag_clear_in) |=> irq)
		else $error("old flag lost");
	a_dec_one: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(xfer_ok && count > `DSC_CNT_ONE && !size_ok) |=> (count == $past(count) - `DSC_CNT_ONE))
		else $error("bad decrement");
	a_hold_wait: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(state == DSC_WAIT && !size_ok) |=> $stable(count))
		else $error("count moved while waiting");
endmodule
`default_nettype wire

// [dsc_sink.sv]
`timescale 1ns/100ps
`default_nettype none
module dsc_sink
	import dsc_pkg::*;
(
	// clock, reset
	input  wire logic      clk_in,
	input  wire logic      arst_n_in,
	// drain side
	input  wire logic      valid_in,
	input  wire dsc_word_t word_in,
	output var  logic      ready_out,
	// control, status
	input  wire logic      stall_in,
	output var  int        rcv_out,
	output var  dsc_word_t last_out
);
	assign ready_out = !stall_in;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rcv_out <= 0;
			last_out <= '0;
		end else if (valid_in && ready_out) begin
			rcv_out <= rcv_out + 1;
			last_out <= word_in;
		end
	end
endmodule
`default_nettype wire

// [tb_dsc_chan.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_dsc_chan
	import dsc_pkg::*;
;
	logic      clk_in, arst_n_in, en_wr, en_val, en_dma, trig, fclr, stall;
	logic      en_o, busy, done, irq, ov, ordy;
	logic [1:0] mode;
	dsc_wr_t   size_wr;
	dsc_word_t src, ow, last;
	dsc_flag_t flag;
	dsc_cnt_t  cnt, v1;
	int        rcv, err_total, comparisons, cyc;
	dsc_chan dsc_chan_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .size_wr_in(size_wr), .enable_wr_in(en_wr),
		.enable_val_in(en_val), .enable_from_dma_in(en_dma), .mode_in(mode), .trig_in(trig), .src_word_in(src),
		.flag_in(flag), .flag_clear_in(fclr), .channel_enable_bit_out(en_o), .transfer_count_register_out(cnt),
		.busy_out(busy), .done_out(done), .irq_flag_out(irq), .out_valid_out(ov), .out_word_out(ow),
		.out_ready_in(ordy));
	dsc_sink dsc_sink_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .valid_in(ov), .word_in(ow),
		.ready_out(ordy), .stall_in(stall), .rcv_out(rcv), .last_out(last));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task tick; @(posedge clk_in); #1; endtask
	task rst_pulse; arst_n_in = 1'b0; repeat (10) tick; arst_n_in = 1'b1; endtask
	task wsize(input dsc_cnt_t d, input logic fd); size_wr = '{1'b1, fd, 3'h0, d}; tick; size_wr.wr = 1'b0; endtask
	task wen(input logic v, input logic fd); en_wr = 1'b1; en_val = v; en_dma = fd; tick; en_wr = 1'b0; endtask
	task wait_done;
		int i;
		for (i = 0; i < 200 && done !== 1'b1; i++) tick;
		`CHK("done", 1'b1, done)
	endtask
	task pulse_flag(input dsc_flag_t f); flag = f; tick; flag = '0; tick; endtask
	task summarize;
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task t_modes;
		int m;
		for (m = 0; m < 4; m++) begin
			rst_pulse;
			mode = m[1:0];
			wsize(16'h0002, 1'b0);
			`CHK("count load", 16'h0002, cnt)
			wen(1'b1, 1'b0);
			`CHK("busy on", 1'b1, busy)
			repeat (5) tick;
			`CHK("count hold", 16'h0002, cnt)
			trig = 1'b1;
			wait_done;
			trig = 1'b0;
			`CHK("count reload", 16'h0002, cnt)
			`CHK("enable after", (m >= 2), en_o)
			`CHK("busy after", (m >= 2), busy)
			repeat (4) tick;
			`CHK("words", 2, rcv)
			`CHK("word", 16'hA5C3, last.data)
		end
	endtask
	task t_active;
		int i;
		rst_pulse;
		mode = 2'h0;
		wsize(16'h0003, 1'b0);
		tick;
		wsize(16'h0005, 1'b1);
		`CHK("dma size", 16'h0003, cnt)
		wen(1'b1, 1'b1);
		tick;
		`CHK("dma enable", 1'b0, en_o)
		wen(1'b1, 1'b0);
		trig = 1'b1;
		for (i = 0; i < 50 && cnt === 16'h0003; i++) tick;
		trig = 1'b0;
		repeat (3) tick;
		`CHK("count dec", 16'h0002, cnt)
		wsize(16'h0006, 1'b0);
		`CHK("active write", 16'h0006, cnt)
		wen(1'b0, 1'b0);
		tick;
		`CHK("no reload", 16'h0006, cnt)
		trig = 1'b1;
		wait_done;
		trig = 1'b0;
		`CHK("shadow", 16'h0003, cnt)
		repeat (4) tick;
		`CHK("words", 7, rcv)
	endtask
	task t_stall;
		stall = 1'b1;
		wen(1'b1, 1'b0);
		trig = 1'b1;
		repeat (20) tick;
		`CHK("valid", 1'b1, ov)
		v1 = cnt;
		repeat (5) tick;
		`CHK("stall hold", v1, cnt)
		`CHK("buffer fill", 16'h0001, cnt)
		stall = 1'b0;
		wait_done;
		trig = 1'b0;
		repeat (4) tick;
		`CHK("drained", 10, rcv)
		`CHK("empty", 1'b0, ov)
	endtask
	task t_flag;
		pulse_flag('{1'b0, 1'b0, 1'b1});
		`CHK("irq set", 1'b1, irq)
		pulse_flag('{1'b1, 1'b1, 1'b1});
		`CHK("irq kept", 1'b1, irq)
		fclr = 1'b1;
		tick;
		fclr = 1'b0;
		tick;
		`CHK("irq clear", 1'b0, irq)
		pulse_flag('{1'b1, 1'b1, 1'b1});
		`CHK("irq lost", 1'b0, irq)
		pulse_flag('{1'b1, 1'b0, 1'b1});
		`CHK("irq rmw only", 1'b1, irq)
		fclr = 1'b1;
		tick;
		fclr = 1'b0;
		tick;
		`CHK("irq clear again", 1'b0, irq)
		fclr = 1'b1;
		flag = '{1'b0, 1'b0, 1'b1};
		tick;
		fclr = 1'b0;
		flag = '0;
		tick;
		`CHK("irq set wins", 1'b1, irq)
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize;
		end
	end
	initial begin
		{arst_n_in, en_wr, en_val, en_dma, trig, fclr, stall, mode} = '0;
		{size_wr, flag} = '0;
		src = 16'hA5C3;
		err_total = 0;
		comparisons = 0;
		cyc = 0;
		t_modes;
		t_active;
		t_stall;
		t_flag;
		summarize;
	end
endmodule
`default_nettype wire
